// >>> design/can_rx_filter_pkg.sv
package can_rx_filter_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address = 4 x index)
  // ---------------------------------------------------------------
  localparam logic [6:0] IDX_MODE = 7'h00;
  localparam logic [6:0] IDX_COMMAND = 7'h01;
  localparam logic [6:0] IDX_STATUS = 7'h02;
  localparam logic [6:0] IDX_TIMING_PRESCALE_JUMP = 7'h06;
  localparam logic [6:0] IDX_TIMING_SEGMENTS = 7'h07;
  localparam logic [6:0] IDX_OUTPUT_DRIVER = 7'h08;
  localparam logic [6:0] IDX_CODE_FIRST = 7'h10;
  localparam logic [6:0] IDX_CODE_LAST = 7'h13;
  localparam logic [6:0] IDX_MASK_FIRST = 7'h14;
  localparam logic [6:0] IDX_MASK_LAST = 7'h17;
  localparam logic [6:0] IDX_MSG_COUNT = 7'h1d;
  localparam logic [6:0] IDX_WINDOW_PTR = 7'h1e;
  localparam logic [6:0] IDX_RAM_FIRST = 7'h20;
  localparam logic [6:0] IDX_RAM_LAST = 7'h5f;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int MODE_RESET_BIT = 0;
  localparam int MODE_FILTER_BIT = 3;
  localparam int MODE_EXTENDED_BIT = 7;
  localparam logic [7:0] MODE_RESET_VALUE = 8'h01;
  localparam int CMD_RELEASE_BIT = 2;
  localparam int CMD_CLEAR_OVERRUN_BIT = 3;
  localparam int JUMP_LSB = 6;
  localparam int SEG1_MSB = 3;
  localparam int SEG2_LSB = 4;
  localparam int SEG2_MSB = 6;
  localparam int SAMPLE_COUNT_BIT = 7;
  localparam logic [7:0] TIMING_RESET_VALUE = 8'h00;
  localparam logic [7:0] FILTER_RESET_VALUE = 8'h00;
  localparam logic [5:0] WINDOW_PTR_RESET = 6'h00;
  localparam logic [7:0] LEGACY_READ_VALUE = 8'hFF;

  // ---------------------------------------------------------------
  // message layout in the receive queue
  // ---------------------------------------------------------------
  localparam int RAM_DEPTH = 64;
  localparam int HDR_BYTES = 5;
  localparam int FRAME_EXT_BIT = 7;
  localparam int FRAME_RTR_BIT = 6;
  localparam logic [5:0] SFF_HDR_LEN = 6'h03;
  localparam logic [5:0] EFF_HDR_LEN = 6'h05;
  localparam logic [3:0] MAX_DATA_BYTES = 4'h8;

  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_BEFORE = 2'b01,
    SEG_AFTER = 2'b11
  } bit_segment_t;

endpackage : can_rx_filter_pkg

// >>> design/can_rx_filter_and_bit_timing.sv
// The APB register port is this design's own decision.
module can_rx_filter_and_bit_timing
  import can_rx_filter_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // received message byte stream
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_last,
  output logic rx_accept,
  // bus level and bit timing
  input wire logic rx_bus,
  output logic tq_tick,
  output logic bit_start,
  output logic sample_point,
  output logic sampled_bit,
  // output driver setup
  output logic [7:0] driver_config
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] mode_reg;
  logic [7:0] bus_timing_prescale_jump;
  logic [7:0] bus_timing_segments;
  logic [7:0] output_driver_control;
  logic [7:0] acceptance_code_byte [4];
  logic [7:0] acceptance_mask_byte [4];
  logic [7:0] receive_message_queue [RAM_DEPTH];
  logic [7:0] hdr [HDR_BYTES];
  logic [7:0] cur [HDR_BYTES];
  logic [4:0] rx_message_count;
  logic [5:0] rx_window_start_pointer;
  logic [5:0] wr_ptr;
  logic [5:0] ptr_pending_val;
  logic ptr_pending;
  logic half_phase;
  logic overrun;
  logic [3:0] rx_idx;
  logic rx_drop;
  logic [7:0] read_byte;

  function automatic logic bpass(input logic [7:0] r, input logic [7:0] c,
                                 input logic [7:0] m);
    return &(m | ~(r ^ c));
  endfunction : bpass

  function automatic logic [3:0] data_count(input logic [7:0] info);
    if (info[FRAME_RTR_BIT]) begin
      return 4'h0;
    end
    return (info[3:0] > MAX_DATA_BYTES) ? MAX_DATA_BYTES : info[3:0];
  endfunction : data_count

  function automatic logic [5:0] msg_len(input logic [7:0] info);
    return (info[FRAME_EXT_BIT] ? EFF_HDR_LEN : SFF_HDR_LEN) + {2'b00, data_count(info)};
  endfunction : msg_len

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire [6:0] idx = paddr[8:2];
  wire word_ok = (paddr[1:0] == 2'b00) && (paddr[11:9] == 3'b000);
  wire is_code = (idx >= IDX_CODE_FIRST) && (idx <= IDX_CODE_LAST);
  wire is_mask = (idx >= IDX_MASK_FIRST) && (idx <= IDX_MASK_LAST);
  wire is_ram = (idx >= IDX_RAM_FIRST) && (idx <= IDX_RAM_LAST);
  wire [5:0] ram_addr = 6'(idx - IDX_RAM_FIRST);
  wire is_reg = (idx == IDX_MODE) || (idx == IDX_COMMAND) || (idx == IDX_STATUS)
             || (idx == IDX_TIMING_PRESCALE_JUMP) || (idx == IDX_TIMING_SEGMENTS)
             || (idx == IDX_OUTPUT_DRIVER) || (idx == IDX_MSG_COUNT)
             || (idx == IDX_WINDOW_PTR);
  wire mapped = word_ok && (is_reg || is_code || is_mask || is_ram);
  wire wr_acc = psel && penable && pwrite && mapped;
  wire rd_setup = psel && !penable && !pwrite;
  wire in_reset_mode = mode_reg[MODE_RESET_BIT];
  wire cfg_wr = wr_acc && in_reset_mode;
  wire legacy_hide = !in_reset_mode && !mode_reg[MODE_EXTENDED_BIT];
  wire enter_reset = wr_acc && (idx == IDX_MODE) && pwdata[MODE_RESET_BIT] && !in_reset_mode;
  wire cmd_wr = wr_acc && (idx == IDX_COMMAND);
  wire release_cmd = cmd_wr && pwdata[CMD_RELEASE_BIT] && !in_reset_mode
                  && (rx_message_count != 5'h00);
  wire ram_wr = cfg_wr && is_ram;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign driver_config = output_driver_control;

  always_comb begin
    read_byte = 8'h00;
    case (idx)
      IDX_MODE: read_byte = mode_reg;
      IDX_STATUS: read_byte = {6'h00, overrun, rx_message_count != 5'h00};
      IDX_TIMING_PRESCALE_JUMP:
        read_byte = legacy_hide ? LEGACY_READ_VALUE : bus_timing_prescale_jump;
      IDX_TIMING_SEGMENTS:
        read_byte = legacy_hide ? LEGACY_READ_VALUE : bus_timing_segments;
      IDX_OUTPUT_DRIVER:
        read_byte = legacy_hide ? LEGACY_READ_VALUE : output_driver_control;
      IDX_MSG_COUNT: read_byte = {3'b000, rx_message_count};
      IDX_WINDOW_PTR: read_byte = {2'b00, rx_window_start_pointer};
      default: begin
        if (is_code) begin
          read_byte = acceptance_code_byte[idx[1:0]];
        end else if (is_mask) begin
          read_byte = acceptance_mask_byte[idx[1:0]];
        end else if (is_ram) begin
          read_byte = receive_message_queue[ram_addr];
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= {24'h00_0000, mapped ? read_byte : 8'h00};
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_RESET_VALUE;
      bus_timing_prescale_jump <= TIMING_RESET_VALUE;
      bus_timing_segments <= TIMING_RESET_VALUE;
      output_driver_control <= TIMING_RESET_VALUE;
    end else begin
      if (wr_acc && idx == IDX_MODE) begin
        mode_reg <= pwdata[7:0];
      end
      if (cfg_wr && idx == IDX_TIMING_PRESCALE_JUMP) begin
        bus_timing_prescale_jump <= pwdata[7:0];
      end
      if (cfg_wr && idx == IDX_TIMING_SEGMENTS) begin
        bus_timing_segments <= pwdata[7:0];
      end
      if (cfg_wr && idx == IDX_OUTPUT_DRIVER) begin
        output_driver_control <= pwdata[7:0];
      end
    end
  end

  // filters only change while reception is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < 4; k++) begin
        acceptance_code_byte[k] <= FILTER_RESET_VALUE;
        acceptance_mask_byte[k] <= FILTER_RESET_VALUE;
      end
    end else if (cfg_wr && is_code) begin
      acceptance_code_byte[idx[1:0]] <= pwdata[7:0];
    end else if (cfg_wr && is_mask) begin
      acceptance_mask_byte[idx[1:0]] <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // acceptance filter
  // ---------------------------------------------------------------
  wire rx_live = rx_byte_valid && !in_reset_mode;

  always_comb begin
    for (int k = 0; k < HDR_BYTES; k++) begin
      cur[k] = (rx_live && rx_idx == 4'(k)) ? rx_byte : hdr[k];
    end
  end

  wire [3:0] dcnt = data_count(cur[0]);
  wire frame_ext = cur[0][FRAME_EXT_BIT];
  wire id_hi_c0 = bpass(cur[1], acceptance_code_byte[0], acceptance_mask_byte[0]);
  wire id_hi_c2 = bpass(cur[1], acceptance_code_byte[2], acceptance_mask_byte[2]);
  wire id_lo_c1 = bpass({cur[2][7:4], 4'h0}, {acceptance_code_byte[1][7:4], 4'h0},
                        {acceptance_mask_byte[1][7:4], 4'hF});
  wire id_lo_c3 = bpass({cur[2][7:4], 4'h0}, {acceptance_code_byte[3][7:4], 4'h0},
                        {acceptance_mask_byte[3][7:4], 4'hF});
  wire single_sff = id_hi_c0 && id_lo_c1
      && (dcnt == 4'h0 || bpass(cur[3], acceptance_code_byte[2], acceptance_mask_byte[2]))
      && (dcnt < 4'h2 || bpass(cur[4], acceptance_code_byte[3], acceptance_mask_byte[3]));
  wire single_eff = id_hi_c0
      && bpass(cur[2], acceptance_code_byte[1], acceptance_mask_byte[1])
      && bpass(cur[3], acceptance_code_byte[2], acceptance_mask_byte[2])
      && bpass(cur[4], acceptance_code_byte[3], acceptance_mask_byte[3] | 8'h03);
  // data byte split across the low nibbles of bytes one and three
  wire data_f1 = bpass(cur[3], {acceptance_code_byte[1][3:0], acceptance_code_byte[3][3:0]},
                       {acceptance_mask_byte[1][3:0], acceptance_mask_byte[3][3:0]});
  wire dual_f1 = frame_ext
      ? id_hi_c0 && bpass(cur[2], acceptance_code_byte[1], acceptance_mask_byte[1])
      : id_hi_c0 && id_lo_c1 && (dcnt == 4'h0 || data_f1);
  wire dual_f2 = frame_ext
      ? id_hi_c2 && bpass(cur[2], acceptance_code_byte[3], acceptance_mask_byte[3])
      : id_hi_c2 && id_lo_c3;
  wire filter_pass = mode_reg[MODE_FILTER_BIT]
      ? (frame_ext ? single_eff : single_sff)
      : (dual_f1 || dual_f2);

  // ---------------------------------------------------------------
  // receive queue
  // ---------------------------------------------------------------
  wire [5:0] rx_waddr = wr_ptr + 6'(rx_idx);
  wire queue_full = (rx_message_count != 5'h00) && (rx_waddr == rx_window_start_pointer);
  wire store = rx_live && !rx_drop && !queue_full && (rx_idx < MAX_DATA_BYTES + 4'h5);
  wire msg_done = rx_live && rx_byte_last;
  wire accept_commit = msg_done && filter_pass && !rx_drop && !queue_full;
  wire overrun_set = msg_done && filter_pass && (rx_drop || queue_full);
  wire [5:0] window_len = msg_len(receive_message_queue[rx_window_start_pointer]);

  // only 64 bytes; a message that meets the window is dropped whole
  always_ff @(posedge pclk) begin
    if (ram_wr) begin
      receive_message_queue[ram_addr] <= pwdata[7:0];
    end else if (store) begin
      receive_message_queue[rx_waddr] <= rx_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < HDR_BYTES; k++) begin
        hdr[k] <= 8'h00;
      end
    end else if (rx_live && rx_idx < 4'(HDR_BYTES)) begin
      hdr[rx_idx[2:0]] <= rx_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_idx <= 4'h0;
      rx_drop <= 1'b0;
      rx_accept <= 1'b0;
    end else begin
      rx_accept <= accept_commit;
      if (in_reset_mode || msg_done) begin
        rx_idx <= 4'h0;
        rx_drop <= 1'b0;
      end else if (rx_live) begin
        rx_idx <= (rx_idx == 4'hF) ? rx_idx : rx_idx + 4'h1;
        rx_drop <= rx_drop || queue_full;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_message_count <= 5'h00;
    end else if (enter_reset || in_reset_mode) begin
      rx_message_count <= 5'h00;
    end else begin
      rx_message_count <= rx_message_count + 5'(accept_commit) - 5'(release_cmd);
    end
  end

  // set wins over the clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= 1'b0;
    end else if (overrun_set) begin
      overrun <= 1'b1;
    end else if (cmd_wr && pwdata[CMD_CLEAR_OVERRUN_BIT]) begin
      overrun <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // window pointer and write pointer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_phase <= 1'b0;
      ptr_pending <= 1'b0;
      ptr_pending_val <= WINDOW_PTR_RESET;
    end else begin
      half_phase <= !half_phase;
      if (cfg_wr && idx == IDX_WINDOW_PTR) begin
        ptr_pending <= 1'b1;
        ptr_pending_val <= pwdata[5:0];
      end else if (half_phase) begin
        ptr_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_window_start_pointer <= WINDOW_PTR_RESET;
    end else if (release_cmd) begin
      rx_window_start_pointer <= rx_window_start_pointer + window_len;
    end else if (ptr_pending && half_phase) begin
      rx_window_start_pointer <= ptr_pending_val;
    end
  end

  // queue empties on reset entry: next message lands on the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= WINDOW_PTR_RESET;
    end else if (enter_reset || in_reset_mode) begin
      wr_ptr <= rx_window_start_pointer;
    end else if (accept_commit) begin
      wr_ptr <= wr_ptr + msg_len(cur[0]);
    end
  end

  // ---------------------------------------------------------------
  // bit timing
  // ---------------------------------------------------------------
  bit_segment_t seg;
  logic [6:0] presc_cnt;
  logic [4:0] seg_cnt;
  logic [2:0] lengthen;
  logic [2:0] shorten;
  logic synced;
  logic rx_prev;
  logic edge_seen;
  logic [1:0] samples;

  wire [6:0] presc_limit = {bus_timing_prescale_jump[5:0], 1'b1};
  wire quantum = !in_reset_mode && (presc_cnt == presc_limit);
  wire [2:0] jump = {1'b0, bus_timing_prescale_jump[7:JUMP_LSB]} + 3'h1;
  wire [4:0] seg1_len = {1'b0, bus_timing_segments[SEG1_MSB:0]} + 5'h01;
  wire [4:0] seg2_len = {2'b00, bus_timing_segments[SEG2_MSB:SEG2_LSB]} + 5'h01;
  wire [4:0] seg1_end = seg1_len + {2'b00, lengthen};
  wire [4:0] seg2_end = seg2_len - {2'b00, shorten};
  wire [4:0] seg2_left = seg2_len - seg_cnt;
  wire resync = edge_seen && !synced;
  wire [2:0] late = (seg_cnt < {2'b00, jump}) ? seg_cnt[2:0] : jump;
  wire majority = (samples[0] & samples[1]) | (samples[0] & rx_bus) | (samples[1] & rx_bus);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt <= 7'h00;
      tq_tick <= 1'b0;
      rx_prev <= 1'b1;
      edge_seen <= 1'b0;
    end else begin
      presc_cnt <= (in_reset_mode || quantum) ? 7'h00 : presc_cnt + 7'h01;
      tq_tick <= quantum;
      rx_prev <= rx_bus;
      edge_seen <= quantum ? 1'b0 : (edge_seen || (rx_prev && !rx_bus));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg <= SEG_SYNC;
      seg_cnt <= 5'h00;
      lengthen <= 3'h0;
      shorten <= 3'h0;
      synced <= 1'b0;
      bit_start <= 1'b0;
      sample_point <= 1'b0;
      sampled_bit <= 1'b1;
      samples <= 2'b11;
    end else begin
      bit_start <= 1'b0;
      sample_point <= 1'b0;
      if (in_reset_mode) begin
        seg <= SEG_SYNC;
        seg_cnt <= 5'h00;
      end else if (quantum) begin
        case (seg)
          SEG_SYNC: begin
            seg <= SEG_BEFORE;
            seg_cnt <= 5'h01;
            lengthen <= 3'h0;
            shorten <= 3'h0;
            synced <= 1'b0;
            bit_start <= 1'b1;
          end
          SEG_BEFORE: begin
            samples <= {samples[0], rx_bus};
            if (resync) begin
              lengthen <= late;
              synced <= 1'b1;
            end
            if (seg_cnt >= seg1_end) begin
              seg <= SEG_AFTER;
              seg_cnt <= 5'h01;
              sample_point <= 1'b1;
              sampled_bit <= bus_timing_segments[SAMPLE_COUNT_BIT] ? majority : rx_bus;
            end else begin
              seg_cnt <= seg_cnt + 5'h01;
            end
          end
          SEG_AFTER: begin
            if (resync && seg2_left <= {2'b00, jump}) begin
              seg <= SEG_BEFORE;
              seg_cnt <= 5'h01;
              lengthen <= 3'h0;
              shorten <= 3'h0;
              synced <= 1'b0;
              bit_start <= 1'b1;
            end else if (resync) begin
              shorten <= jump;
              synced <= 1'b1;
              seg_cnt <= seg_cnt + 5'h01;
            end else if (seg_cnt >= seg2_end) begin
              seg <= SEG_SYNC;
              seg_cnt <= 5'h00;
            end else begin
              seg_cnt <= seg_cnt + 5'h01;
            end
          end
          default: seg <= SEG_SYNC;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [6:0] tq_gap;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq_gap <= 7'h00;
    end else begin
      tq_gap <= (quantum || in_reset_mode) ? 7'h00 : tq_gap + 7'h01;
    end
  end

  sequence s_ptr_write;
    cfg_wr && idx == IDX_WINDOW_PTR && !release_cmd;
  endsequence

  // spacing from the quantum formula itself: 2 x (prescaler + 1) clocks
  AST_QUANTUM_PERIOD: assert property (quantum
      |-> tq_gap == 7'(2 * bus_timing_prescale_jump[5:0] + 1))
    else $error("quantum period wrong");
  AST_RESERVED_ZERO: assert property (rd_setup && word_ok
      && (idx == IDX_MSG_COUNT || idx == IDX_WINDOW_PTR) |=> prdata[31:6] == 26'h0)
    else $error("unused bits not zero");
  // a reset-mode entry in the same cycle clears the count instead
  AST_COUNT_UP: assert property (accept_commit && !release_cmd && !enter_reset
      |=> rx_message_count == $past(rx_message_count) + 5'h01)
    else $error("count did not increment");
  AST_RELEASE_ADVANCE: assert property (release_cmd
      |=> rx_window_start_pointer == $past(rx_window_start_pointer + window_len))
    else $error("pointer not advanced");
  // the write lands on one of the next two half-rate edges
  AST_PTR_DELAYED: assert property (s_ptr_write
      |-> (##2 rx_window_start_pointer == $past(pwdata[5:0], 2))
      or (##3 rx_window_start_pointer == $past(pwdata[5:0], 3)))
    else $error("pointer write not applied");
  AST_PTR_READONLY: assert property (wr_acc && idx == IDX_WINDOW_PTR
      && !in_reset_mode && !ptr_pending && !release_cmd |=> $stable(rx_window_start_pointer))
    else $error("pointer written in operating mode");
  AST_LEGACY_ONES: assert property (rd_setup && legacy_hide && word_ok
      && idx == IDX_TIMING_SEGMENTS |=> prdata[7:0] == LEGACY_READ_VALUE)
    else $error("legacy read not all ones");
  AST_RESET_EMPTIES: assert property (enter_reset
      |=> rx_message_count == 5'h00 && wr_ptr == $past(rx_window_start_pointer))
    else $error("queue not emptied");
  AST_DUAL_EITHER: assert property (accept_commit && !mode_reg[MODE_FILTER_BIT]
      |-> dual_f1 || dual_f2)
    else $error("dual accept without match");
  AST_WRAP: assert property (accept_commit && !enter_reset
      |=> wr_ptr == 6'($past(wr_ptr) + $past(msg_len(cur[0]))))
    else $error("write pointer wrong");

endmodule : can_rx_filter_and_bit_timing

// >>> testbench/can_peer.sv
module can_peer
(
  // clock
  input wire logic pclk,
  // byte stream toward the filter
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_byte_last,
  // bus level, recessive while idle
  output logic rx_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    rx_byte_last = 1'b0;
    rx_bus = 1'b1;
  end
  // n bytes in queue layout, first byte in the top lane of b
  task automatic send_msg(input logic [39:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= b[39 - 8 * i -: 8];
      rx_byte_last <= (i == n - 1);
      @(posedge pclk);
    end
    rx_byte_valid <= 1'b0;
    rx_byte_last <= 1'b0;
    // released byte lane must not look like a held value
    rx_byte <= ~rx_byte;
    // idle edge keeps the next message off this release step
    @(posedge pclk);
  endtask : send_msg
  task automatic set_bus(input logic level);
    rx_bus <= level;
  endtask : set_bus
endmodule : can_peer

// >>> testbench/tb_can_rx_filter_and_bit_timing.sv
module tb_can_rx_filter_and_bit_timing;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sel = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, rx_byte_valid, rx_byte_last, rx_accept, rx_bus;
  logic tq_tick, bit_start, err, sample_point, sampled_bit;
  logic [7:0] rx_byte, driver_config;
  int mismatches = 0, check_count = 0, cycles = 0, accepts = 0, gap;
  wire pick = sel ? bit_start : tq_tick;
  always #2.5 pclk = ~pclk;
  can_rx_filter_and_bit_timing dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_byte_valid, .rx_byte, .rx_byte_last,
    .rx_accept, .rx_bus, .tq_tick, .bit_start, .sample_point, .sampled_bit,
    .driver_config);
  can_peer peer (.pclk, .rx_byte_valid, .rx_byte, .rx_byte_last, .rx_bus);
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [6:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {3'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle keeps the next setup off this release edge
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input logic [6:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask : rdchk
  task automatic msg(input logic [39:0] b, input int n, input int exp);
    int base;
    base = accepts;
    peer.send_msg(b, n);
    @(posedge pclk);
    chk(accepts - base, exp);
  endtask : msg
  // the first sample point may still see the old level, so judge the second
  task automatic sample_check(input logic level);
    peer.set_bus(level);
    repeat (2) begin
      @(posedge pclk);
      while (sample_point !== 1'b1) @(posedge pclk);
    end
    chk(sampled_bit, level);
  endtask : sample_check
  task automatic spacing(input logic s);
    sel = s;
    @(posedge pclk);
    while (pick !== 1'b1) @(posedge pclk);
    @(posedge pclk);
    gap = 1;
    while (pick !== 1'b1) begin
      @(posedge pclk);
      gap++;
    end
  endtask : spacing
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  always @(posedge pclk) begin
    cycles++;
    if (rx_accept === 1'b1) accepts++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(7'h1d, 8'h00);
    rdchk(7'h1e, 8'h00);
    apb(1'b1, 7'h06, 8'h02);
    apb(1'b1, 7'h07, 8'h01);
    apb(1'b1, 7'h08, 8'hA5);
    rdchk(7'h08, 8'hA5);
    chk(driver_config, 8'hA5);
    apb(1'b0, 7'h7f, 8'h00);
    chk(err, 1'b1);
    apb(1'b1, 7'h1e, 8'hFF);
    repeat (2) @(posedge pclk);
    rdchk(7'h1e, 8'h3F);
    apb(1'b1, 7'h1e, 8'h00);
    apb(1'b1, 7'h10, 8'h12);
    apb(1'b1, 7'h12, 8'h34);
    apb(1'b1, 7'h15, 8'hFF);
    apb(1'b1, 7'h17, 8'hFF);
    apb(1'b1, 7'h00, 8'h80);
    apb(1'b1, 7'h06, 8'h3F);
    rdchk(7'h06, 8'h02);
    spacing(1'b0);
    chk(gap, 6);
    spacing(1'b1);
    chk(gap, 24);
    msg(40'h01_3400_AA00, 4, 1);
    msg(40'h01_5600_AA00, 4, 0);
    msg(40'h01_1200_AA00, 4, 1);
    repeat (2) @(posedge pclk);
    chk(accepts, 2);
    rdchk(7'h1d, 8'h02);
    apb(1'b1, 7'h01, 8'h04);
    rdchk(7'h1d, 8'h01);
    rdchk(7'h1e, 8'h04);
    rdchk(7'h25, 8'h12);
    apb(1'b1, 7'h00, 8'h00);
    rdchk(7'h07, 8'hFF);
    apb(1'b1, 7'h00, 8'h01);
    rdchk(7'h1d, 8'h00);
    rdchk(7'h1e, 8'h04);
    apb(1'b1, 7'h11, 8'h0A);
    apb(1'b1, 7'h13, 8'h0A);
    apb(1'b1, 7'h15, 8'h00);
    apb(1'b1, 7'h17, 8'h03);
    apb(1'b1, 7'h1e, 8'h3E);
    apb(1'b1, 7'h00, 8'h80);
    msg(40'h01_1200_AA00, 4, 1);
    rdchk(7'h21, 8'hAA);
    msg(40'h01_1200_BA00, 4, 0);
    msg(40'h00_1200_0000, 3, 1);
    msg(40'h80_120A_7777, 5, 1);
    msg(40'h80_341A_7777, 5, 0);
    apb(1'b1, 7'h00, 8'h88);
    msg(40'h80_120A_340B, 5, 1);
    msg(40'h80_120A_350A, 5, 0);
    apb(1'b1, 7'h1e, 8'h10);
    rdchk(7'h1e, 8'h3E);
    rdchk(7'h1d, 8'h04);
    apb(1'b1, 7'h01, 8'h04);
    rdchk(7'h1e, 8'h02);
    sample_check(1'b0);
    sample_check(1'b1);
    give_verdict();
  end
endmodule : tb_can_rx_filter_and_bit_timing
